// File: design/spi_flags_clocking_config.sv
// What this block does
// - Set transfer done after every byte.
// - Flags raise interrupt; only software clears them.
// - Data write with full buffer flags collision.
// - Colliding write is dropped, buffer kept.
// - Master in multi-master mode, select low: fault.
// - Mode fault clears master and enable bits.
// - Slave completion with unread byte flags overrun.
// - Overrun keeps old byte, drops new one.
// - Config bit 5 selects clock phase.
// - Phase 0 first edge, 1 second edge.
// - Config bit 4 sets clock idle level.
// - Bit-rate divider only used as master.
// - Master rate at most half clock, 12.5MHz.
// - Transmit-only slave receives up to quarter clock.
// - Busy bit 7 high during any transfer.
// - Config bit 6 chooses slave or master.
// - Select mode 01 makes select an input.
// - Bytes shift most significant bit first.
// - Slave counts edges, completes after eight bits.
`timescale 1ns/1ns
`default_nettype none

module spi_flags_clocking_config (
  // Clock and reset.
  input  wire  logic       core_clk,
  input  wire  logic       rst_n,
  // Special function register port.
  input  wire  logic [7:0] sfr_addr,
  input  wire  logic       sfr_wr,
  input  wire  logic       sfr_rd,
  input  wire  logic [7:0] sfr_wdata,
  output logic       [7:0] sfr_rdata,
  // Interrupt.
  input  wire  logic       int_enable,
  output logic             irq,
  // Serial clock pin.
  input  wire  logic       sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  // Master-out data pin.
  input  wire  logic       mosi_in,
  output logic             mosi_out,
  output logic             mosi_oe,
  // Master-in data pin.
  input  wire  logic       miso_in,
  output logic             miso_out,
  output logic             miso_oe,
  // Select pin.
  input  wire  logic       select_line_in,
  output logic             select_line_out,
  output logic             select_line_oe
);
  import spi_flags_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic        master_select_q, clock_phase_select_q, clock_polarity_select_q;
  logic        unit_enable_q;
  logic [1:0]  select_line_mode_q;
  logic        done_flag_q, write_collision_flag_flag_q, mode_fault_flag_flag_q, ovr_flag_q;
  logic [7:0]  bit_rate_divider_q;
  logic [7:0]  tx_buf_q, rx_hold_q, shifter_q;
  logic        tx_full_q, rx_full_q, loaded_q, out_bit_q;
  logic [3:0]  edge_idx_q;
  logic [8:0]  div_cnt_q;
  logic        sck_q, sck_prev_q, sel_prev_q, selected_q;
  logic        sck_oe_q, mosi_oe_q, miso_oe_q, sel_out_q, sel_oe_q, irq_q;
  logic [7:0]  rdata_q;
  xfer_state_t state_q;

  // ----------------------------------------------------------------
  // Decode and shared events
  // ----------------------------------------------------------------
  logic       wr_cfg, wr_ctl, wr_ckr, wr_dat, rd_dat;
  logic       multi_mode, selected, slave_act, busy;
  logic [8:0] half_lim;
  logic       edge_ev, sample_edge, last_edge, din;
  logic [7:0] shift_next, rx_byte;
  logic       start_master, load_ev, mode_fault_flag_ev, write_collision_flag_ev, sel_fall;
  logic       unread, push_ok, ovr_ev, buf_in_ready, buf_out_valid, buf_pop;
  logic [7:0] buf_out_data;

  assign wr_cfg = sfr_wr && (sfr_addr == CFG_ADDR);
  assign wr_ctl = sfr_wr && (sfr_addr == CTL_ADDR);
  assign wr_ckr = sfr_wr && (sfr_addr == CKR_ADDR);
  assign wr_dat = sfr_wr && (sfr_addr == DAT_ADDR);
  assign rd_dat = sfr_rd && (sfr_addr == DAT_ADDR);

  // Select is an input only in mode 01; three-wire mode is always selected.
  assign multi_mode = (select_line_mode_q == MD_MULTI);
  assign selected   = (select_line_mode_q == MD_THREE) || !select_line_in;
  assign slave_act  = unit_enable_q && !master_select_q && selected;
  assign sel_fall   = multi_mode && sel_prev_q && !select_line_in;

  // Half period is the divider plus one, floored so the master never
  // outruns half the core clock or the absolute rate ceiling.
  assign half_lim = ({1'b0, bit_rate_divider_q} + 9'h001 < MIN_HALF) ? MIN_HALF
                  : {1'b0, bit_rate_divider_q} + 9'h001;

  // Master edges come from the divider, slave edges from the pin.
  assign edge_ev = master_select_q
                 ? (state_q == XFER_ACTIVE) && (div_cnt_q == half_lim - 9'h001)
                 : slave_act && (sck_in != sck_prev_q);

  // Phase 0 samples on even edges (first of each bit), phase 1 on odd.
  assign sample_edge = edge_ev && (edge_idx_q[0] == clock_phase_select_q);
  assign last_edge   = edge_ev && (edge_idx_q == LAST_EDGE);
  assign din         = master_select_q ? miso_in : mosi_in;
  assign shift_next  = {shifter_q[6:0], din};
  assign rx_byte     = sample_edge ? shift_next : shifter_q;

  // Master waits for buffer room so a finished byte always has a slot.
  assign start_master = (state_q == XFER_IDLE) && unit_enable_q && master_select_q
                      && tx_full_q && buf_in_ready;
  assign load_ev = start_master
                 || (!master_select_q && unit_enable_q && tx_full_q
                     && (!loaded_q || last_edge) && (edge_idx_q == 4'h0 || last_edge));

  assign mode_fault_flag_ev = master_select_q && multi_mode && !select_line_in;
  assign write_collision_flag_ev = wr_dat && tx_full_q;

  // A byte still in the buffer or the holding register counts as unread.
  assign unread  = rx_full_q || buf_out_valid;
  assign push_ok = last_edge && (master_select_q || (!unread && buf_in_ready));
  assign ovr_ev  = last_edge && !master_select_q && (unread || !buf_in_ready);
  assign buf_pop = buf_out_valid && (!rx_full_q || master_select_q);

  assign busy = (state_q == XFER_ACTIVE)
              || (!master_select_q && edge_idx_q != 4'h0);

  // ----------------------------------------------------------------
  // Receive path buffer
  // ----------------------------------------------------------------
  // Dropped bytes never enter, so the buffer holds at most one in slave use.
  rx_two_entry_fifo #(
    .WIDTH (8),
    .DEPTH (2)
  ) u_rx_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (push_ok),
    .in_data   (rx_byte),
    .in_ready  (buf_in_ready),
    .out_valid (buf_out_valid),
    .out_data  (buf_out_data),
    .out_ready (!rx_full_q || master_select_q)
  );

  // ----------------------------------------------------------------
  // Configuration and control bits
  // ----------------------------------------------------------------
  // A mode fault wins over a software write in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      master_select_q         <= CFG_RESET[CFG_MST_BIT];
      clock_phase_select_q    <= CFG_RESET[CFG_PHA_BIT];
      clock_polarity_select_q <= CFG_RESET[CFG_POL_BIT];
      unit_enable_q           <= CTL_RESET[CTL_EN_BIT];
      select_line_mode_q      <= CTL_RESET[CTL_MD_HI_BIT:CTL_MD_LO_BIT];
      bit_rate_divider_q      <= CKR_RESET;
    end else begin
      if (wr_cfg) begin
        master_select_q         <= sfr_wdata[CFG_MST_BIT];
        clock_phase_select_q    <= sfr_wdata[CFG_PHA_BIT];
        clock_polarity_select_q <= sfr_wdata[CFG_POL_BIT];
      end
      if (wr_ctl) begin
        unit_enable_q      <= sfr_wdata[CTL_EN_BIT];
        select_line_mode_q <= sfr_wdata[CTL_MD_HI_BIT:CTL_MD_LO_BIT];
      end
      if (wr_ckr) begin
        bit_rate_divider_q <= sfr_wdata;
      end
      if (mode_fault_flag_ev) begin
        master_select_q <= 1'b0;
        unit_enable_q   <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------
  // Hardware never clears these; a set in the clearing cycle still wins.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      done_flag_q <= CTL_RESET[CTL_DONE_BIT];
      write_collision_flag_flag_q <= CTL_RESET[CTL_WRITE_COLLISION_FLAG_BIT];
      mode_fault_flag_flag_q <= CTL_RESET[CTL_MODE_FAULT_FLAG_BIT];
      ovr_flag_q  <= CTL_RESET[CTL_OVR_BIT];
    end else begin
      done_flag_q <= (wr_ctl ? sfr_wdata[CTL_DONE_BIT] : done_flag_q) || last_edge;
      write_collision_flag_flag_q <= (wr_ctl ? sfr_wdata[CTL_WRITE_COLLISION_FLAG_BIT] : write_collision_flag_flag_q) || write_collision_flag_ev;
      mode_fault_flag_flag_q <= (wr_ctl ? sfr_wdata[CTL_MODE_FAULT_FLAG_BIT] : mode_fault_flag_flag_q) || mode_fault_flag_ev;
      ovr_flag_q  <= (wr_ctl ? sfr_wdata[CTL_OVR_BIT] : ovr_flag_q) || ovr_ev;
    end
  end

  // ----------------------------------------------------------------
  // Transmit and receive holding registers
  // ----------------------------------------------------------------
  // A write into a full transmit buffer is thrown away untouched.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tx_buf_q  <= ZERO_BYTE;
      tx_full_q <= 1'b0;
      rx_hold_q <= ZERO_BYTE;
      rx_full_q <= 1'b0;
    end else begin
      if (wr_dat && !tx_full_q) begin
        tx_buf_q  <= sfr_wdata;
        tx_full_q <= 1'b1;
      end else if (load_ev) begin
        tx_full_q <= 1'b0;
      end
      if (buf_pop) begin
        rx_hold_q <= buf_out_data;
        rx_full_q <= 1'b1;
      end else if (rd_dat) begin
        rx_full_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Shift engine
  // ----------------------------------------------------------------
  // The outgoing bit is updated on non-sampling edges so it is stable
  // across the sampling edge in both phase settings.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shifter_q <= ZERO_BYTE;
      out_bit_q <= 1'b0;
      loaded_q  <= 1'b0;
    end else begin
      if (load_ev) begin
        shifter_q <= tx_buf_q;
        out_bit_q <= tx_buf_q[7];
      end else if (sample_edge) begin
        shifter_q <= shift_next;
      end else if (edge_ev) begin
        out_bit_q <= shifter_q[7];
      end
      if (load_ev) begin
        loaded_q <= 1'b1;
      end else if (last_edge || !unit_enable_q) begin
        loaded_q <= 1'b0;
      end
    end
  end

  // Edge counter; in three-wire slave use only a disable resets it.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      edge_idx_q <= 4'h0;
    end else if (!unit_enable_q || start_master || (sel_fall && !master_select_q)) begin
      edge_idx_q <= 4'h0;
    end else if (edge_ev) begin
      edge_idx_q <= edge_idx_q + 4'h1;
    end
  end

  // Master sequencer and divider.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_q   <= XFER_IDLE;
      div_cnt_q <= 9'h000;
    end else begin
      unique case (state_q)
        XFER_IDLE: begin
          div_cnt_q <= 9'h000;
          if (start_master) begin
            state_q <= XFER_ACTIVE;
          end
        end
        XFER_ACTIVE: begin
          div_cnt_q <= edge_ev ? 9'h000 : div_cnt_q + 9'h001;
          if (last_edge || !unit_enable_q || !master_select_q) begin
            state_q <= XFER_IDLE;
          end
        end
      endcase
    end
  end

  // Serial clock rests at the polarity level outside a transfer.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sck_q <= CFG_RESET[CFG_POL_BIT];
    end else if (state_q != XFER_ACTIVE) begin
      sck_q <= clock_polarity_select_q;
    end else if (edge_ev) begin
      sck_q <= ~sck_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin sampling, drivers and interrupt
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b0;
      sel_prev_q <= 1'b1;
      selected_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_in;
      sel_prev_q <= select_line_in;
      selected_q <= !select_line_in;
    end
  end

  // Enables are registered so every pin output comes from a flop.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sck_oe_q  <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      sel_out_q <= 1'b1;
      sel_oe_q  <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      sck_oe_q  <= unit_enable_q && master_select_q;
      mosi_oe_q <= unit_enable_q && master_select_q;
      miso_oe_q <= slave_act;
      sel_out_q <= select_line_mode_q[0];
      sel_oe_q  <= unit_enable_q && select_line_mode_q[1];
      irq_q     <= int_enable
                && (done_flag_q || write_collision_flag_flag_q || mode_fault_flag_flag_q || ovr_flag_q);
    end
  end

  // ----------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------
  // Data read returns the holding register; the flag drop is above.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_q <= ZERO_BYTE;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        CFG_ADDR: rdata_q <= {busy, master_select_q, clock_phase_select_q,
                              clock_polarity_select_q, selected_q, select_line_in,
                              master_select_q || (!loaded_q && edge_idx_q == 4'h0),
                              master_select_q || !rx_full_q};
        CTL_ADDR: rdata_q <= {done_flag_q, write_collision_flag_flag_q, mode_fault_flag_flag_q, ovr_flag_q,
                              select_line_mode_q, !tx_full_q, unit_enable_q};
        CKR_ADDR: rdata_q <= bit_rate_divider_q;
        DAT_ADDR: rdata_q <= rx_hold_q;
        default:  rdata_q <= ZERO_BYTE;
      endcase
    end
  end

  assign sfr_rdata       = rdata_q;
  assign irq             = irq_q;
  assign sck_out         = sck_q;
  assign sck_oe          = sck_oe_q;
  assign mosi_out        = out_bit_q;
  assign mosi_oe         = mosi_oe_q;
  assign miso_out        = out_bit_q;
  assign miso_oe         = miso_oe_q;
  assign select_line_out = sel_out_q;
  assign select_line_oe  = sel_oe_q;

endmodule : spi_flags_clocking_config

`default_nettype wire

// File: design/spi_flags_pkg.sv
package spi_flags_pkg;

  // ----------------------------------------------------------------
  // Register addresses on the special function register port
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_ADDR  = 8'hA1;
  localparam logic [7:0] CKR_ADDR  = 8'hA2;
  localparam logic [7:0] DAT_ADDR  = 8'hA3;
  localparam logic [7:0] CTL_ADDR  = 8'hF8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_BUSY_BIT  = 7;
  localparam int CFG_MST_BIT   = 6;
  localparam int CFG_PHA_BIT   = 5;
  localparam int CFG_POL_BIT   = 4;
  localparam int CFG_SEL_BIT   = 3;
  localparam int CFG_SELECT_LINE_RAW_INPUT_BIT = 2;
  localparam int CFG_SHIFTER_EMPTY_BIT  = 1;
  localparam int CFG_RECEIVE_BUFFER_EMPTY_BIT = 0;
  localparam int CTL_DONE_BIT  = 7;
  localparam int CTL_WRITE_COLLISION_FLAG_BIT  = 6;
  localparam int CTL_MODE_FAULT_FLAG_BIT  = 5;
  localparam int CTL_OVR_BIT   = 4;
  localparam int CTL_MD_HI_BIT = 3;
  localparam int CTL_MD_LO_BIT = 2;
  localparam int CTL_TXE_BIT   = 1;
  localparam int CTL_EN_BIT    = 0;

  // ----------------------------------------------------------------
  // Reset values and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG_RESET    = 8'h07;
  localparam logic [7:0] CTL_RESET    = 8'h06;
  localparam logic [7:0] CKR_RESET    = 8'h00;
  localparam logic [1:0] MD_THREE     = 2'h0;
  localparam logic [1:0] MD_MULTI     = 2'h1;
  localparam logic [3:0] LAST_EDGE    = 4'hF;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint SYS_CLK_HZ     = 25_000_000;
  localparam longint MAX_MASTER_HZ  = 12_500_000;
  localparam longint MIN_HALF_RAW   = (SYS_CLK_HZ + 2 * MAX_MASTER_HZ - 1) / (2 * MAX_MASTER_HZ);
  localparam logic [8:0] MIN_HALF   = (MIN_HALF_RAW < 1) ? 9'h001 : 9'(MIN_HALF_RAW);

  typedef enum logic {XFER_IDLE, XFER_ACTIVE} xfer_state_t;

endpackage : spi_flags_pkg

// File: design/rx_two_entry_fifo.sv
`timescale 1ns/1ns
`default_nettype none

module rx_two_entry_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset.
  input  wire  logic             core_clk,
  input  wire  logic             rst_n,
  // Filling side.
  input  wire  logic             in_valid,
  input  wire  logic [WIDTH-1:0] in_data,
  output logic                   in_ready,
  // Draining side.
  output logic                   out_valid,
  output logic [WIDTH-1:0]       out_data,
  input  wire  logic             out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("rx_two_entry_fifo needs a power-of-two depth of at least 2.");
    end
  endgenerate

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_ptr_q;
  logic [PW-1:0]    rd_ptr_q;
  logic [PW:0]      count_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_q != (PW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign out_data  = mem_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage is written only on an accepted push.
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers wrap naturally because the depth is a power of two.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : rx_two_entry_fifo

`default_nettype wire

// File: tb/spi_flags_checker.sv
`timescale 1ns/1ns
`default_nettype none

module spi_flags_checker (
  // Clock and reset.
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Register port.
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  // Interrupt.
  input  wire logic       int_enable,
  input  wire logic       irq,
  // Pin controls.
  input  wire logic       sck_out,
  input  wire logic       sck_oe,
  input  wire logic       mosi_oe,
  input  wire logic       miso_oe,
  input  wire logic       select_line_in,
  input  wire logic       select_line_oe
);
  import spi_flags_pkg::*;
  logic [1:0] mode_q;
  logic       pol_q;

  // Shadow the fields that only software changes, so the pins can be judged against them.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mode_q <= MD_MULTI;
      pol_q  <= 1'b0;
    end else if (sfr_wr && sfr_addr == CTL_ADDR) begin
      mode_q <= sfr_wdata[CTL_MD_HI_BIT:CTL_MD_LO_BIT];
    end else if (sfr_wr && sfr_addr == CFG_ADDR) begin
      pol_q <= sfr_wdata[CFG_POL_BIT];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_irq_off;
    !int_enable |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("irq high while interrupts are disabled");
  property p_flag_hold;
    irq && int_enable && !$past(sfr_wr) |=> irq;
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("irq dropped without a software clear");
  property p_master_pins;
    sck_oe == mosi_oe;
  endproperty
  a_master_pins: assert property (p_master_pins)
    else $error("clock and data drivers disagree on master role");
  property p_one_role;
    !(sck_oe && miso_oe);
  endproperty
  a_one_role: assert property (p_one_role)
    else $error("port drives as master and slave at once");
  property p_sel_input;
    (mode_q == MD_MULTI)[*3] |-> !select_line_oe;
  endproperty
  a_sel_input: assert property (p_sel_input)
    else $error("select pin driven in multi-master mode");
  property p_unsel_quiet;
    (select_line_in && mode_q == MD_MULTI)[*4] |-> !miso_oe;
  endproperty
  a_unsel_quiet: assert property (p_unsel_quiet)
    else $error("slave output driven while not selected");
  property p_mode_fault;
    sck_oe && mode_q == MD_MULTI && !select_line_in |-> ##[1:3] !sck_oe;
  endproperty
  a_mode_fault: assert property (p_mode_fault)
    else $error("master kept driving after select went low");
  property p_idle_level;
    ($stable(sck_out) && $stable(pol_q) && sck_oe)[*8] |-> sck_out == pol_q;
  endproperty
  a_idle_level: assert property (p_idle_level)
    else $error("serial clock idles at the wrong level");
endmodule : spi_flags_checker

bind spi_flags_clocking_config spi_flags_checker i_checker (
  .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
  .sfr_wdata(sfr_wdata), .int_enable(int_enable), .irq(irq), .sck_out(sck_out),
  .sck_oe(sck_oe), .mosi_oe(mosi_oe), .miso_oe(miso_oe),
  .select_line_in(select_line_in), .select_line_oe(select_line_oe));

`default_nettype wire

// File: tb/far_end_slave_model.sv
`timescale 1ns/1ns
`default_nettype none

module far_end_slave_model (
  // Clock and frame.
  input  wire logic       core_clk,
  input  wire logic       frame_on,
  // Settings that must match the port.
  input  wire logic       pha,
  input  wire logic [7:0] tx_byte,
  // Serial pins.
  input  wire logic       sck,
  input  wire logic       mosi,
  output logic            miso,
  // Last byte taken from the port.
  output logic [7:0]      got
);
  logic [3:0] cnt_q = 4'h0;
  logic [7:0] sh_q  = 8'h00;
  logic [7:0] rx_q  = 8'h00;
  logic       sck_q = 1'b0;
  logic       bit_q = 1'b0;
  logic       tog_q = 1'b0;
  logic       samp;
  logic [7:0] nxt;

  assign samp = (cnt_q[0] == pha);
  assign nxt  = {rx_q[6:0], mosi};
  // A released line toggles every cycle so a stale bit can never pass for data.
  assign miso = !frame_on ? tog_q : (pha ? bit_q : sh_q[7]);

  // Edges are seen one system clock late, so the port must not run near its limit here.
  always_ff @(posedge core_clk) begin
    sck_q <= sck;
    tog_q <= ~tog_q;
    if (!frame_on) begin
      cnt_q <= 4'h0;
      sh_q  <= tx_byte;
    end else if (sck != sck_q) begin
      cnt_q <= cnt_q + 4'h1;
      if (samp) begin
        rx_q <= nxt;
      end else begin
        bit_q <= sh_q[7];
        sh_q  <= {sh_q[6:0], 1'b0};
      end
      if (cnt_q == 4'hF) begin
        got  <= samp ? nxt : rx_q;
        sh_q <= tx_byte;
      end
    end
  end
endmodule : far_end_slave_model

`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import spi_flags_pkg::*;
  typedef struct packed {logic [7:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic       core_clk, rst_n, sfr_wr, sfr_rd, int_enable, sck_in, mosi_in, sel_in, pha;
  logic [7:0] sfr_addr, sfr_wdata, rdata, tx_byte, sfr_rdata, got, so;
  logic       irq, sck_out, sck_oe, mosi_out, miso, miso_out, sel_out;
  logic [2:0] m;
  int         mismatches, n_compared, r;
  row_t       rows [6] = '{'{CFG_ADDR, 8'hF0, 8'h77}, '{CFG_ADDR, 8'h8F, 8'h07},
                           '{CKR_ADDR, 8'h03, 8'h03}, '{8'h55, 8'hFF, 8'h00},
                           '{CTL_ADDR, 8'h00, 8'h02}, '{CTL_ADDR, 8'h0C, 8'h0E}};

  spi_flags_clocking_config i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .int_enable(int_enable), .irq(irq), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(),
    .miso_in(miso), .miso_out(miso_out), .miso_oe(), .select_line_in(sel_in),
    .select_line_out(sel_out), .select_line_oe());

  far_end_slave_model i_far (
    .core_clk(core_clk), .frame_on(sck_oe), .pha(pha), .tx_byte(tx_byte),
    .sck(sck_out), .mosi(mosi_out), .miso(miso), .got(got));

  // The clock runs free at 25 MHz.
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) #1;
    sfr_addr  = a;
    sfr_wdata = d;
    sfr_wr    = 1'b1;
    @(posedge core_clk) #1;
    sfr_wr = 1'b0;
  endtask : wr

  // Read data is registered, so it is taken one edge after the strobe drops.
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk) #1;
    sfr_addr = a;
    sfr_rd   = 1'b1;
    @(posedge core_clk) #1;
    sfr_rd = 1'b0;
    @(posedge core_clk) #1;
    rdata = sfr_rdata;
  endtask : rd

  task automatic wait_done();
    int i;
    for (i = 0; i < 200; i++) begin
      rd(CTL_ADDR);
      if (rdata[CTL_DONE_BIT] === 1'b1) break;
    end
    if (i == 200) begin
      mismatches++;
      finish_test();
    end
  endtask : wait_done

  // Synchronous outside master, polarity 0, phase 0, h cycles per half bit
  task automatic slv_byte(input logic [7:0] b, input int h);
    int k;
    for (k = 7; k >= 0; k--) begin
      mosi_in = b[k];
      repeat (h) @(posedge core_clk) #1;
      so     = {so[6:0], miso_out};
      sck_in = 1'b1;
      repeat (h) @(posedge core_clk) #1;
      sck_in = 1'b0;
    end
  endtask : slv_byte

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n, sfr_wr, sfr_rd, int_enable, sck_in, mosi_in, pha} = 7'h00;
    {sfr_addr, sfr_wdata, tx_byte} = 24'h000000;
    sel_in = 1'b1;
    repeat (10) @(posedge core_clk) #1;
    rst_n = 1'b1;
    rd(CFG_ADDR);
    chk(rdata, CFG_RESET, "config reset");
    rd(CTL_ADDR);
    chk(rdata, CTL_RESET, "control reset");
    $display("test reset done");
    for (r = 0; r < 6; r++) begin
      wr(rows[r].a, rows[r].d);
      rd(rows[r].a);
      chk(rdata, rows[r].e, "register readback");
    end
    chk({7'h00, sel_out}, 8'h01, "select drive level");
    $display("test registers done");
    for (m = 3'h0; m < 3'h4; m++) begin
      wr(CTL_ADDR, 8'h00);
      pha     = m[1];
      tx_byte = {m[1:0], 6'h1B};
      wr(CFG_ADDR, {2'b01, m[1:0], 4'h0});
      wr(CTL_ADDR, 8'h01);
      wr(DAT_ADDR, {6'h30, m[1:0]});
      rd(CFG_ADDR);
      chk({7'h00, rdata[CFG_BUSY_BIT]}, 8'h01, "busy");
      wait_done();
      chk(got, {6'h30, m[1:0]}, "far end byte");
      rd(DAT_ADDR);
      chk(rdata, tx_byte, "received byte");
      chk({7'h00, sck_out}, {7'h00, m[0]}, "idle clock");
    end
    $display("test clocking modes done");
    wr(CTL_ADDR, 8'h01);
    wr(DAT_ADDR, 8'h11);
    wr(DAT_ADDR, 8'h22);
    wr(DAT_ADDR, 8'h33);
    wait_done();
    rd(CTL_ADDR);
    chk({7'h00, rdata[CTL_WRITE_COLLISION_FLAG_BIT]}, 8'h01, "collision flag");
    wr(CTL_ADDR, 8'h01);
    wait_done();
    chk(got, 8'h22, "buffered byte");
    $display("test collision done");
    int_enable = 1'b1;
    wr(CTL_ADDR, 8'h05);
    sel_in = 1'b0;
    repeat (4) @(posedge core_clk) #1;
    rd(CTL_ADDR);
    chk(rdata, 8'h26, "control after fault");
    rd(CFG_ADDR);
    chk({7'h00, rdata[CFG_MST_BIT]}, 8'h00, "master after fault");
    chk({7'h00, irq}, 8'h01, "irq raised");
    sel_in = 1'b1;
    wr(CTL_ADDR, 8'h04);
    repeat (2) @(posedge core_clk) #1;
    chk({7'h00, irq}, 8'h00, "irq cleared");
    $display("test mode fault done");
    wr(CFG_ADDR, 8'h00);
    repeat (4) rd(DAT_ADDR);
    wr(CTL_ADDR, 8'h01);
    slv_byte(8'h3C, 2);
    wr(DAT_ADDR, 8'hA5);
    slv_byte(8'hC3, 5);
    chk(so, 8'hA5, "slave sent byte");
    repeat (4) @(posedge core_clk) #1;
    rd(CTL_ADDR);
    chk(rdata & 8'h91, 8'h91, "done and overrun");
    rd(DAT_ADDR);
    chk(rdata, 8'h3C, "kept byte");
    $display("test slave overrun done");
    finish_test();
  end
endmodule : testbench

`default_nettype wire
